// ==== cpu_program_flow_control.sv ====
// Program-flow core: four-phase instruction cycle, prefetch pipeline,
// 12-bit program counter, return stack, interrupt gating and ALU.
// Assumes program memory returns data for prog_addr by phase four,
// and an AXI4-Lite master on the register port.
// Operation
// RL1: Four phases form one instruction cycle
// RL2: Phase one advances counter, starts fetch
// RL3: Phases two to four execute prefetched instruction
// RL4: Fetch overlaps execution, one per cycle
// RL5: Branches take two cycles each
// RL6: Counter increments by one otherwise
// RL7: Twelve-bit counter, only low byte accessible
// RL8: Low-byte write jumps within page
// RL9: Low-byte write inserts one dummy cycle
// RL10: Taken skip discards prefetch, dummy cycle
// RL11: Jumps, calls, interrupts load target directly
// RL12: Return stack hidden from software
// RL13: Call or acknowledge pushes counter
// RL14: Returns pop stack into counter
// RL15: Reset points stack to top
// RL16: Full stack holds interrupt until return
// RL17: Call on full stack overwrites oldest
// RL18: ALU writes result and flags
// RL19: ALU supports all operation classes
// RL20: Stack depth parameter, level gives full/empty
module cpu_program_flow_control #(
  parameter int          STACK_DEPTH = 8,
  parameter logic [11:0] IRQ_VECTOR  = 12'h004
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Program memory
  output logic [11:0]      prog_addr,
  input  wire logic [15:0] prog_data,
  // Interrupt and instruction phase
  input  wire logic        irq_req,
  output logic             irq_ack,
  output logic [1:0]       instruction_phases
);

  localparam int SP_W  = $clog2(STACK_DEPTH);
  localparam int LVL_W = $clog2(STACK_DEPTH + 1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(STACK_DEPTH);
  localparam logic [LVL_W-1:0] LVL_ONE  = LVL_W'(1);

  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
    $error("STACK_DEPTH must be a power of two of at least 2");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  flow_pkg::phase_e  phase_q;
  logic [11:0]       pc_q, pc_d;
  logic [15:0]       ir_q;
  logic              ir_valid_q;
  logic [7:0]        acc_q;
  logic [3:0]        flags_q;
  logic              emi_q, irq_pend_q, ack_q;
  logic              pcl_pend_q;
  logic [7:0]        pcl_data_q;
  logic [11:0]       stack_mem [STACK_DEPTH];
  logic [SP_W-1:0]   sp_q;
  logic [LVL_W-1:0]  level_q;
  logic [7:0]        alu_res;
  logic [3:0]        alu_flags;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == flow_pkg::REG_PCL) || (a == flow_pkg::REG_STATUS) ||
             (a == flow_pkg::REG_CONTROL);
  endfunction

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  logic t4;
  assign t4 = (phase_q == flow_pkg::PH_T4);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= flow_pkg::PH_T1;
    end else begin
      unique case (phase_q) // [RL1]
        flow_pkg::PH_T1: phase_q <= flow_pkg::PH_T2;
        flow_pkg::PH_T2: phase_q <= flow_pkg::PH_T3;
        flow_pkg::PH_T3: phase_q <= flow_pkg::PH_T4;
        flow_pkg::PH_T4: phase_q <= flow_pkg::PH_T1;
      endcase
    end
  end

  assign instruction_phases = phase_q;

  // ----------------------------------------------------------------------
  // Decode and flow control
  // ----------------------------------------------------------------------
  logic [3:0]  opc;
  logic        exec, full, empty, flow, skip_hit;
  logic        irq_take, pcl_take, push, pop, flush, alu_wr;
  logic [11:0] stack_top;

  assign opc       = ir_q[flow_pkg::OP_MSB:flow_pkg::OP_LSB];
  assign exec      = t4 && ir_valid_q; // [RL3]
  assign full      = (level_q == LVL_FULL); // [RL20]
  assign empty     = (level_q == '0);
  assign stack_top = stack_mem[SP_W'(sp_q - 1'b1)];
  assign skip_hit  = exec && opc == flow_pkg::OP_SKIP_Z && acc_q == 8'h00;
  assign flow      = skip_hit || (exec && (opc == flow_pkg::OP_JUMP ||
                     opc == flow_pkg::OP_CALL || opc == flow_pkg::OP_SUB_RET ||
                     opc == flow_pkg::OP_INT_RET || opc == flow_pkg::OP_WR_PCL));
  assign irq_take  = t4 && irq_pend_q && emi_q && !full && !flow; // [RL16]
  assign pcl_take  = t4 && pcl_pend_q && !flow && !irq_take;
  assign alu_wr    = exec && opc == flow_pkg::OP_ALU;

  always_comb begin
    pc_d  = pc_q;
    flush = 1'b0;
    push  = 1'b0;
    pop   = 1'b0;
    if (t4) begin
      pc_d = pc_q + flow_pkg::PC_STEP; // [RL6] [RL4]
      if (irq_take) begin
        pc_d  = IRQ_VECTOR; // [RL11]
        push  = 1'b1; // [RL13]
        flush = 1'b1;
      end else if (pcl_take) begin
        pc_d  = {pc_q[11:8], pcl_data_q}; // [RL8] [RL7]
        flush = 1'b1; // [RL9]
      end else if (exec) begin
        unique case (opc)
          flow_pkg::OP_JUMP: begin
            pc_d  = ir_q[flow_pkg::TGT_MSB:0]; // [RL11]
            flush = 1'b1; // [RL5]
          end
          flow_pkg::OP_CALL: begin
            pc_d  = ir_q[flow_pkg::TGT_MSB:0];
            push  = 1'b1; // [RL13] [RL17]
            flush = 1'b1;
          end
          flow_pkg::OP_SUB_RET, flow_pkg::OP_INT_RET: begin
            pc_d  = stack_top; // [RL14]
            pop   = 1'b1;
            flush = 1'b1;
          end
          flow_pkg::OP_SKIP_Z: flush = skip_hit; // [RL10]
          flow_pkg::OP_WR_PCL: begin
            pc_d  = {pc_q[11:8], acc_q}; // [RL8]
            flush = 1'b1; // [RL9]
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter and prefetch pipeline
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q       <= flow_pkg::RESET_VECTOR; // [RL11]
      ir_q       <= '0;
      ir_valid_q <= 1'b0;
    end else if (t4) begin
      pc_q       <= pc_d; // [RL2]
      ir_q       <= prog_data; // [RL4]
      ir_valid_q <= !flush;
    end
  end

  assign prog_addr = pc_q;

  // ----------------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (push) begin
      stack_mem[sp_q] <= pc_q; // [RL13] [RL12]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q    <= '0; // [RL15]
      level_q <= '0;
    end else if (push) begin
      sp_q <= SP_W'(sp_q + 1'b1); // [RL17]
      if (!full) level_q <= LVL_W'(level_q + LVL_ONE);
    end else if (pop && !empty) begin
      sp_q    <= SP_W'(sp_q - 1'b1); // [RL14]
      level_q <= LVL_W'(level_q - LVL_ONE);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pend_q <= 1'b0;
      ack_q      <= 1'b0;
    end else begin
      ack_q <= irq_take;
      if (irq_req) irq_pend_q <= 1'b1; // [RL16]
      else if (irq_take) irq_pend_q <= 1'b0;
    end
  end

  assign irq_ack = ack_q;

  // ----------------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------------
  flow_alu u_alu (
    .op        (ir_q[flow_pkg::AOP_MSB:flow_pkg::AOP_LSB]),
    .a         (acc_q),
    .b         (ir_q[flow_pkg::IMM_MSB:0]),
    .flags_in  (flags_q),
    .res       (alu_res),
    .flags_out (alu_flags)
  ); // [RL19]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q   <= '0;
      flags_q <= '0;
    end else if (alu_wr) begin
      acc_q   <= alu_res; // [RL18]
      flags_q <= alu_flags;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q, wr_go;
  logic [3:0]  aw_addr_q, w_strb_q;
  logic [31:0] w_data_q, rdata_q;
  logic [1:0]  bresp_q, rresp_q;

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready  = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= flow_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) ? flow_pkg::RESP_OKAY : flow_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  logic pcl_wr, ctl_wr;
  assign pcl_wr = wr_go && aw_addr_q == flow_pkg::REG_PCL && w_strb_q[0];
  assign ctl_wr = wr_go && aw_addr_q == flow_pkg::REG_CONTROL && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcl_pend_q <= 1'b0;
      pcl_data_q <= '0;
    end else if (pcl_wr) begin
      pcl_pend_q <= 1'b1; // [RL9]
      pcl_data_q <= w_data_q[7:0];
    end else if (pcl_take) begin
      pcl_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emi_q <= 1'b0;
    end else if (irq_take) begin
      emi_q <= 1'b0;
    end else if (exec && opc == flow_pkg::OP_INT_RET) begin
      emi_q <= 1'b1;
    end else if (ctl_wr) begin
      emi_q <= w_data_q[flow_pkg::CTL_EMI];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= flow_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(araddr) ? flow_pkg::RESP_OKAY : flow_pkg::RESP_SLVERR;
      rdata_q  <= '0;
      unique case (araddr)
        flow_pkg::REG_PCL: rdata_q[7:0] <= pc_q[7:0]; // [RL7]
        flow_pkg::REG_STATUS: begin
          rdata_q[flow_pkg::ST_ACC_LSB +: 8]  <= acc_q;
          rdata_q[flow_pkg::ST_FLG_LSB +: 4]  <= flags_q;
          rdata_q[flow_pkg::ST_PEND_BIT]      <= irq_pend_q;
        end
        flow_pkg::REG_CONTROL: rdata_q[flow_pkg::CTL_EMI] <= emi_q;
        default: ;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_phase_ring;
    @(posedge aclk) disable iff (!aresetn)
    phase_q == flow_pkg::PH_T1 |=> phase_q == flow_pkg::PH_T2 ##1
      phase_q == flow_pkg::PH_T3 ##1 phase_q == flow_pkg::PH_T4 ##1 phase_q == flow_pkg::PH_T1;
  endproperty
  a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken"); // [RL1]

  property p_pc_only_t1;
    @(posedge aclk) disable iff (!aresetn) !t4 |=> $stable(pc_q);
  endproperty
  a_pc_only_t1: assert property (p_pc_only_t1) else $error("pc moved off phase"); // [RL2]

  property p_seq_step;
    @(posedge aclk) disable iff (!aresetn)
    t4 && !flow && !irq_take && !pcl_take |=> pc_q == $past(pc_q) + 12'h001 && ir_valid_q;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("pc not incremented"); // [RL6]

  property p_jump_two;
    @(posedge aclk) disable iff (!aresetn)
    exec && !irq_take && !pcl_take && opc == flow_pkg::OP_JUMP |=>
      pc_q == $past(ir_q[11:0]) && !ir_valid_q ##3 t4 && !ir_valid_q;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles"); // [RL5]

  property p_pcl_page;
    @(posedge aclk) disable iff (!aresetn)
    pcl_take |=> pc_q[11:8] == $past(pc_q[11:8]) && pc_q[7:0] == $past(pcl_data_q)
      && !ir_valid_q;
  endproperty
  a_pcl_page: assert property (p_pcl_page) else $error("low-byte jump wrong"); // [RL8]

  property p_skip_dummy;
    @(posedge aclk) disable iff (!aresetn) skip_hit |=> !ir_valid_q;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("skip kept prefetch"); // [RL10]

  property p_push_level;
    @(posedge aclk) disable iff (!aresetn)
    push |=> level_q == ($past(full) ? $past(level_q) : $past(level_q) + LVL_ONE);
  endproperty
  a_push_level: assert property (p_push_level) else $error("push level wrong"); // [RL17]

  property p_ret_pop;
    @(posedge aclk) disable iff (!aresetn) pop |=> pc_q == $past(stack_top);
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return address wrong"); // [RL14]

  property p_full_hold;
    @(posedge aclk) disable iff (!aresetn) full && irq_pend_q |=> irq_pend_q && !irq_ack;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("ack on full stack"); // [RL16]

  property p_alu_wr;
    @(posedge aclk) disable iff (!aresetn)
    alu_wr |=> acc_q == $past(alu_res) && flags_q == $past(alu_flags);
  endproperty
  a_alu_wr: assert property (p_alu_wr) else $error("alu result lost"); // [RL18]

  c_irq_ack:  cover property (@(posedge aclk) disable iff (!aresetn) irq_take);
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) push && full);
  c_pcl_jump: cover property (@(posedge aclk) disable iff (!aresetn) pcl_take);

endmodule // cpu_program_flow_control

// ==== flow_pkg.sv ====
// Shared constants for the program-flow core: instruction layout, ALU ops,
// register offsets and field positions.
// Assumes one 20 MHz clock and an AXI4-Lite master for the register port.
package flow_pkg;

  // ----------------------------------------------------------------------
  // Widths and vectors
  // ----------------------------------------------------------------------
  localparam int             PC_W         = 12;
  localparam int             PCL_W        = 8;
  localparam int             DATA_W       = 8;
  localparam int             INSN_W       = 16;
  localparam int             AXI_AW       = 4;
  localparam logic [11:0]    RESET_VECTOR = 12'h000;
  localparam logic [11:0]    PC_STEP      = 12'h001;
  localparam int             PHASE_COUNT  = 4;

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 12;
  localparam int AOP_MSB = 11;
  localparam int AOP_LSB = 8;
  localparam int IMM_MSB = 7;
  localparam int TGT_MSB = 11;

  // ----------------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------------
  localparam logic [3:0] OP_NOP      = 4'h0;
  localparam logic [3:0] OP_ALU      = 4'h1;
  localparam logic [3:0] OP_JUMP     = 4'h2;
  localparam logic [3:0] OP_CALL     = 4'h3;
  localparam logic [3:0] OP_SUB_RET  = 4'h4;
  localparam logic [3:0] OP_INT_RET  = 4'h5;
  localparam logic [3:0] OP_SKIP_Z   = 4'h6;
  localparam logic [3:0] OP_WR_PCL   = 4'h7;

  // ----------------------------------------------------------------------
  // ALU operations
  // ----------------------------------------------------------------------
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_ADC = 4'h1;
  localparam logic [3:0] ALU_SUB = 4'h2;
  localparam logic [3:0] ALU_SBC = 4'h3;
  localparam logic [3:0] ALU_DEC_ADJ = 4'h4;
  localparam logic [3:0] ALU_AND = 4'h5;
  localparam logic [3:0] ALU_OR  = 4'h6;
  localparam logic [3:0] ALU_XOR = 4'h7;
  localparam logic [3:0] ALU_CPL = 4'h8;
  localparam logic [3:0] ALU_RR  = 4'h9;
  localparam logic [3:0] ALU_RRC = 4'ha;
  localparam logic [3:0] ALU_RL  = 4'hb;
  localparam logic [3:0] ALU_RLC = 4'hc;
  localparam logic [3:0] ALU_INC = 4'hd;
  localparam logic [3:0] ALU_DEC = 4'he;
  localparam logic [3:0] ALU_MOV = 4'hf;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;

  // ----------------------------------------------------------------------
  // Registers and fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_PCL     = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h8;
  localparam int ST_ACC_LSB  = 0;
  localparam int ST_FLG_LSB  = 8;
  localparam int ST_PEND_BIT = 12;
  localparam int FLG_C  = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int CTL_EMI = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_e;

endpackage

// ==== flow_alu.sv ====
// Combinational 8-bit ALU with carry, half carry, zero and overflow.
// Assumes the caller latches result and flags when it executes.
module flow_alu (
  // Operation
  input  wire logic [3:0] op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [3:0] flags_in,
  // Result
  output logic      [7:0] res,
  output logic      [3:0] flags_out
);

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  logic [8:0] sum9;
  logic [4:0] half;
  logic [7:0] bx;
  logic [7:0] adj;
  logic       ci;
  logic       arith;

  always_comb begin
    res       = a;
    flags_out = flags_in;
    arith     = 1'b0;
    bx        = b;
    ci        = 1'b0;
    adj       = 8'h00;
    unique case (op)
      flow_pkg::ALU_ADD: begin arith = 1'b1; end
      flow_pkg::ALU_ADC: begin arith = 1'b1; ci = flags_in[flow_pkg::FLG_C]; end
      flow_pkg::ALU_SUB: begin arith = 1'b1; bx = ~b; ci = 1'b1; end
      flow_pkg::ALU_SBC: begin arith = 1'b1; bx = ~b; ci = flags_in[flow_pkg::FLG_C]; end
      flow_pkg::ALU_INC: begin arith = 1'b1; bx = 8'h00; ci = 1'b1; end
      flow_pkg::ALU_DEC: begin arith = 1'b1; bx = 8'hff; end
      default: ;
    endcase
    sum9 = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
    half = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    if (arith) begin
      res = sum9[7:0];
      flags_out[flow_pkg::FLG_C]  = sum9[8];
      flags_out[flow_pkg::FLG_AC] = half[4];
      flags_out[flow_pkg::FLG_OV] = (a[7] == bx[7]) && (sum9[7] != a[7]);
    end
    unique case (op)
      flow_pkg::ALU_DEC_ADJ: begin
        if (a[3:0] > flow_pkg::BCD_LIMIT || flags_in[flow_pkg::FLG_AC])
          adj = adj | flow_pkg::BCD_LO_FIX;
        if (a[7:4] > flow_pkg::BCD_LIMIT || flags_in[flow_pkg::FLG_C])
          adj = adj | flow_pkg::BCD_HI_FIX;
        sum9 = {1'b0, a} + {1'b0, adj};
        res  = sum9[7:0];
        flags_out[flow_pkg::FLG_C] = sum9[8] | flags_in[flow_pkg::FLG_C];
      end
      flow_pkg::ALU_AND: res = a & b;
      flow_pkg::ALU_OR:  res = a | b;
      flow_pkg::ALU_XOR: res = a ^ b;
      flow_pkg::ALU_CPL: res = ~a;
      flow_pkg::ALU_RR:  res = {a[0], a[7:1]};
      flow_pkg::ALU_RRC: begin
        res = {flags_in[flow_pkg::FLG_C], a[7:1]};
        flags_out[flow_pkg::FLG_C] = a[0];
      end
      flow_pkg::ALU_RL:  res = {a[6:0], a[7]};
      flow_pkg::ALU_RLC: begin
        res = {a[6:0], flags_in[flow_pkg::FLG_C]};
        flags_out[flow_pkg::FLG_C] = a[7];
      end
      flow_pkg::ALU_MOV: res = b;
      default: ;
    endcase
    flags_out[flow_pkg::FLG_Z] = (res == 8'h00);
  end

endmodule // flow_alu

// ==== prog_mem_model.sv ====
// Program memory and interrupt source standing beside the flow core.
// Assumes the bench fills mem before reset release and pulses irq_fire.
module prog_mem_model (
  // Clock
  input  wire logic        aclk,
  // Fetch port
  input  wire logic [11:0] prog_addr,
  output logic      [15:0] prog_data,
  // Interrupt source
  input  wire logic        irq_fire,
  output logic             irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:4095];
  // ----------------------------------------------------------------------
  // Fetch and request
  // ----------------------------------------------------------------------
  assign prog_data = mem[prog_addr];
  always @(posedge aclk) begin
    irq_req <= irq_fire;
  end
endmodule // prog_mem_model

// ==== cpu_program_flow_control_tb.sv ====
// Self-checking bench for the program-flow core.
// Assumes prog_mem_model as program memory and a bench AXI4-Lite master.
module cpu_program_flow_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq_fire, irq_req, irq_ack;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, instruction_phases;
  logic [11:0] prog_addr;
  logic [15:0] prog_data;
  int          mismatches, total_checks, n;
  // Rows: program word at an address, then expected fetch order
  localparam logic [27:0] PROG [10] = '{28'h000_1f00, 28'h001_6000, 28'h002_20ff,
    28'h003_3310, 28'h004_2500, 28'h310_1f42, 28'h311_4000, 28'h500_7000, 28'h542_2542,
    28'h520_3520};
  localparam logic [11:0] EXP [16] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004,
    12'h310, 12'h311, 12'h312, 12'h004, 12'h005, 12'h500, 12'h501, 12'h542, 12'h543,
    12'h542, 12'h543};

  cpu_program_flow_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .prog_addr, .prog_data, .irq_req, .irq_ack,
    .instruction_phases);
  prog_mem_model pm (.aclk, .prog_addr, .prog_data, .irq_fire, .irq_req);

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  task automatic wait_addr(input logic [11:0] a);
    n = 0;
    while (prog_addr !== a && n < 80) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk("reach", 32'(prog_addr), 32'(a));
  endtask

  task automatic fetch_run;
    for (int i = 0; i < 16; i++) begin
      chk("fetch", 32'(prog_addr), 32'(EXP[i]));
      for (int k = 1; k < 4; k++) begin
        @(posedge aclk);
        #1;
        chk("phase", 32'(instruction_phases), k);
        chk("held", 32'(prog_addr), 32'(EXP[i]));
      end
      @(posedge aclk);
      #1;
    end
    $display("test fetch done");
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_fire} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    for (int i = 0; i < 4096; i++) pm.mem[i] = 16'h0000;
    foreach (PROG[i]) pm.mem[PROG[i][27:16]] = PROG[i][15:0];
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    fetch_run();
    axi_rd(flow_pkg::REG_STATUS, rd, rs);
    chk("acc", 32'(rd[7:0]), 32'h42);
    axi_rd(flow_pkg::REG_PCL, rd, rs);
    chk("pcl", rd & 32'hffff_fffe, 32'h42);
    axi_rd(4'hc, rd, rs);
    chk("rd unmapped", 32'(rs), 32'(flow_pkg::RESP_SLVERR));
    axi_wr(4'hc, 32'h1, rs);
    chk("wr unmapped", 32'(rs), 32'(flow_pkg::RESP_SLVERR));
    $display("test registers done");
    axi_wr(flow_pkg::REG_CONTROL, 32'h1, rs);
    @(posedge aclk);
    irq_fire <= 1'b1;
    @(posedge aclk);
    irq_fire <= 1'b0;
    n = 0;
    while (irq_ack !== 1'b1 && n < 40) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk("ack", 32'(irq_ack), 32'h1);
    wait_addr(12'h004);
    $display("test interrupt done");
    wait_addr(12'h543);
    axi_wr(flow_pkg::REG_PCL, 32'h10, rs);
    chk("pcl wr", 32'(rs), 32'(flow_pkg::RESP_OKAY));
    wait_addr(12'h510);
    $display("test pcl write done");
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    #1;
    chk("rst addr", 32'(prog_addr), 32'h0);
    chk("rst ack", 32'(irq_ack), 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    fetch_run();
    axi_wr(flow_pkg::REG_PCL, 32'h20, rs);
    wait_addr(12'h520);
    repeat (80) @(posedge aclk);
    axi_wr(flow_pkg::REG_CONTROL, 32'h1, rs);
    @(posedge aclk);
    irq_fire <= 1'b1;
    @(posedge aclk);
    irq_fire <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      #1;
      if (irq_ack !== 1'b0) n++;
    end
    chk("ack on full", 32'(n), 32'h0);
    axi_rd(flow_pkg::REG_STATUS, rd, rs);
    chk("pending", 32'(rd[flow_pkg::ST_PEND_BIT]), 32'h1);
    $display("test full stack done");
    give_verdict();
  end
endmodule // cpu_program_flow_control_tb
